//--- timer_group.sv
// Tick timer, dual down-counter, wake-up timer and two watchdogs
`timescale 1ns/1ps
// What this block does
// - Divide the 2 MHz RC clock by 64 into a roughly 31.25 kHz sleep clock.
// - Wake-up timer is a 32-bit down-counter stepped only by the sleep clock.
// - Single-shot wake-up timer raises interrupt and wake request on expiry, then stops.
// - Auto-reload wake-up timer raises both on expiry, reloads and keeps counting.
// - Wake-up expiry drives both a processor interrupt and a chip wake request.
// - Two independent 32-bit down-counters, each raising an interrupt on expiry.
// - Each counter runs free-running, periodic or one-shot, as selected.
// - Processor configures and reads the dual timer; here through plain ports.
// - 32-bit tick timer issues a recurring tick at a software-set interval.
// - Each watchdog interrupts the processor unless serviced before it expires.
// - Watchdog interrupt also leaves as a core output usable as CPU reset.
// - Watchdog expiry with interrupt still pending applies a system reset.
module timer_group #(
    parameter int CNT_W     = timer_pkg::CNT_WIDTH,
    parameter int SLEEP_DIV = timer_pkg::SLEEP_DIV_RATIO
) (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_arst_n,
    // Sleep clock source
    input  wire logic                  i_rc2m_clk,
    output logic                       o_sleep_clk,
    output logic                       o_sleep_tick,
    // Periodic tick timer
    input  wire logic                  i_tick_en,
    input  wire logic [CNT_W-1:0]      i_tick_interval,
    output logic                       o_tick,
    // Dual timer
    input  wire logic [1:0]            i_dt_en,
    input  wire logic [1:0]            i_dt_load_wr,
    input  wire timer_pkg::dt_mode_t   i_dt0_mode,
    input  wire timer_pkg::dt_mode_t   i_dt1_mode,
    input  wire logic [CNT_W-1:0]      i_dt0_load,
    input  wire logic [CNT_W-1:0]      i_dt1_load,
    input  wire logic [1:0]            i_dt_irq_clr,
    output logic [1:0]                 o_dt_irq,
    output logic [CNT_W-1:0]           o_dt0_count,
    output logic [CNT_W-1:0]           o_dt1_count,
    // Wake-up timer
    input  wire logic                  i_wk_en,
    input  wire logic                  i_wk_autoreload,
    input  wire logic                  i_wk_load_wr,
    input  wire logic [CNT_W-1:0]      i_wk_load,
    input  wire logic                  i_wk_irq_clr,
    input  wire logic                  i_wk_wake_clr,
    output logic                       o_wk_irq,
    output logic                       o_wk_wake,
    output logic [CNT_W-1:0]           o_wk_count,
    // Watchdogs
    input  wire logic [1:0]            i_wd_en,
    input  wire logic [1:0]            i_wd_service,
    input  wire logic [CNT_W-1:0]      i_wd0_timeout,
    input  wire logic [CNT_W-1:0]      i_wd1_timeout,
    input  wire logic [1:0]            i_wd_irq_clr,
    output logic [1:0]                 o_wd_irq,
    output logic                       o_wd_core_irq,
    output logic                       o_sys_rst
);
    import timer_pkg::*;

    localparam int DIV_W = $clog2(SLEEP_DIV);
    localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(SLEEP_DIV - 1);
    localparam logic [RST_CNT_W-1:0] RST_LEN = RST_CNT_W'(WD_RST_CYCLES);

    // Refused at elaboration, before any logic is built
    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt_w
        $error("CNT_W must lie between 2 and 32");
    end
    if (SLEEP_DIV < 4 || (SLEEP_DIV & (SLEEP_DIV - 1)) != 0) begin : g_bad_div
        $error("SLEEP_DIV must be a power of two, at least 4");
    end
    if (WD_RST_CYCLES >= (1 << RST_CNT_W)) begin : g_bad_rst
        $error("Reset pulse does not fit its counter");
    end

    typedef struct packed {
        logic                  rc_s1;
        logic                  rc_s2;
        logic                  rc_s3;
        logic [DIV_W-1:0]      div;
        logic                  sleep_clk;
        logic                  sleep_tick;
        logic                  tick_run;
        logic [CNT_W-1:0]      tick_cnt;
        logic                  tick;
        logic [1:0][CNT_W-1:0] dt_cnt;
        logic [1:0]            dt_stop;
        logic [1:0]            dt_irq;
        logic [CNT_W-1:0]      wk_cnt;
        logic                  wk_stop;
        logic                  wk_irq;
        logic                  wk_wake;
        logic [1:0]            wd_run;
        logic [1:0][CNT_W-1:0] wd_cnt;
        logic [1:0]            wd_irq;
        logic                  wd_core;
        logic [RST_CNT_W-1:0]  rst_cnt;
        logic                  sys_rst;
    } state_t;

    state_t s;
    state_t next_s;

    logic [1:0][CNT_W-1:0] dt_load;
    logic [1:0][CNT_W-1:0] wd_timeout;
    dt_mode_t              dt_mode [2];
    logic                  rc_rise;
    logic [1:0]            dt_fire;
    logic                  wk_fire;
    logic [1:0]            wd_fire;

    assign dt_load    = {i_dt1_load, i_dt0_load};
    assign wd_timeout = {i_wd1_timeout, i_wd0_timeout};
    assign dt_mode[0] = i_dt0_mode;
    assign dt_mode[1] = i_dt1_mode;
    // Edge taken after the second stage only
    assign rc_rise    = s.rc_s2 & ~s.rc_s3;
    assign wk_fire    = s.sleep_tick & i_wk_en & ~s.wk_stop & ~i_wk_load_wr & (s.wk_cnt == '0);

    // Count value after a zero is reached, by mode
    function automatic logic [CNT_W-1:0] dt_wrap(input dt_mode_t mode,
                                                 input logic [CNT_W-1:0] cnt,
                                                 input logic [CNT_W-1:0] load);
        case (mode)
            MODE_PERIODIC: dt_wrap = load;
            MODE_ONESHOT:  dt_wrap = cnt;
            default:       dt_wrap = '1;
        endcase
    endfunction

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            dt_fire[i] = i_dt_en[i] & ~s.dt_stop[i] & ~i_dt_load_wr[i] & (s.dt_cnt[i] == '0);
            wd_fire[i] = i_wd_en[i] & s.wd_run[i] & ~i_wd_service[i] & (s.wd_cnt[i] == '0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s = s;
        // Sleep clock divider
        next_s.rc_s1      = i_rc2m_clk;
        next_s.rc_s2      = s.rc_s1;
        next_s.rc_s3      = s.rc_s2;
        next_s.sleep_tick = 1'b0;
        if (rc_rise) begin
            next_s.div = s.div + 1'b1;
            if (s.div[DIV_W-2:0] == '1)
                next_s.sleep_clk = ~s.sleep_clk;
            if (s.div == DIV_MAX)
                next_s.sleep_tick = 1'b1;
        end

        // Tick timer, period is interval plus one cycle
        next_s.tick = 1'b0;
        if (!i_tick_en) begin
            next_s.tick_run = 1'b0;
        end else if (!s.tick_run || s.tick_cnt == '0) begin
            next_s.tick_run = 1'b1;
            next_s.tick_cnt = i_tick_interval;
            next_s.tick     = s.tick_run;
        end else begin
            next_s.tick_cnt = s.tick_cnt - 1'b1;
        end

        // Dual timer; clear first so a same-cycle expiry wins
        for (int i = 0; i < 2; i++) begin
            if (i_dt_irq_clr[i])
                next_s.dt_irq[i] = 1'b0;
            if (i_dt_load_wr[i]) begin
                next_s.dt_cnt[i]  = dt_load[i];
                next_s.dt_stop[i] = 1'b0;
            end else if (dt_fire[i]) begin
                next_s.dt_irq[i] = 1'b1;
                next_s.dt_cnt[i] = dt_wrap(dt_mode[i], s.dt_cnt[i], dt_load[i]);
                if (dt_mode[i] == MODE_ONESHOT)
                    next_s.dt_stop[i] = 1'b1;
            end else if (i_dt_en[i] && !s.dt_stop[i]) begin
                next_s.dt_cnt[i] = s.dt_cnt[i] - 1'b1;
            end
        end

        // Wake-up timer, stepped by the sleep tick
        if (i_wk_irq_clr)
            next_s.wk_irq = 1'b0;
        if (i_wk_wake_clr)
            next_s.wk_wake = 1'b0;
        if (i_wk_load_wr) begin
            next_s.wk_cnt  = i_wk_load;
            next_s.wk_stop = 1'b0;
        end else if (wk_fire) begin
            next_s.wk_irq  = 1'b1;
            next_s.wk_wake = 1'b1;
            if (i_wk_autoreload)
                next_s.wk_cnt = i_wk_load;
            else
                next_s.wk_stop = 1'b1;
        end else if (s.sleep_tick && i_wk_en && !s.wk_stop) begin
            next_s.wk_cnt = s.wk_cnt - 1'b1;
        end

        // Watchdogs
        if (s.rst_cnt != '0)
            next_s.rst_cnt = s.rst_cnt - 1'b1;
        for (int i = 0; i < 2; i++) begin
            if (i_wd_irq_clr[i])
                next_s.wd_irq[i] = 1'b0;
            if (!i_wd_en[i]) begin
                next_s.wd_run[i] = 1'b0;
            end else if (!s.wd_run[i] || i_wd_service[i]) begin
                next_s.wd_run[i] = 1'b1;
                next_s.wd_cnt[i] = wd_timeout[i];
            end else if (wd_fire[i]) begin
                // Pending interrupt left unanswered means software is lost
                if (s.wd_irq[i])
                    next_s.rst_cnt = RST_LEN;
                next_s.wd_irq[i] = 1'b1;
                next_s.wd_cnt[i] = wd_timeout[i];
            end else begin
                next_s.wd_cnt[i] = s.wd_cnt[i] - 1'b1;
            end
        end
        next_s.wd_core = |next_s.wd_irq;
        next_s.sys_rst = next_s.rst_cnt != '0;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign o_sleep_clk   = s.sleep_clk;
    assign o_sleep_tick  = s.sleep_tick;
    assign o_tick        = s.tick;
    assign o_dt_irq      = s.dt_irq;
    assign o_dt0_count   = s.dt_cnt[0];
    assign o_dt1_count   = s.dt_cnt[1];
    assign o_wk_irq      = s.wk_irq;
    assign o_wk_wake     = s.wk_wake;
    assign o_wk_count    = s.wk_cnt;
    assign o_wd_irq      = s.wd_irq;
    assign o_wd_core_irq = s.wd_core;
    assign o_sys_rst     = s.sys_rst;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);

    sequence wd_second_expiry;
        wd_fire[0] && s.wd_irq[0] && !i_wd_irq_clr[0];
    endsequence
    sequence rst_pulse;
        o_sys_rst [*8];
    endsequence

    AST_SLEEP_TICK: assert property (o_sleep_tick |-> $past(s.div) == DIV_MAX && s.div == '0)
        else $error("sleep tick off the divide count");
    AST_SLEEP_CLK: assert property ($changed(o_sleep_clk) |-> $past(rc_rise))
        else $error("sleep clock moved without a source edge");
    AST_WK_HOLD: assert property (!o_sleep_tick && !i_wk_load_wr |=> $stable(o_wk_count))
        else $error("wake counter moved off the sleep tick");
    AST_WK_DOWN: assert property (o_sleep_tick && i_wk_en && !s.wk_stop && !i_wk_load_wr
                                  && o_wk_count != '0
                                  |=> o_wk_count == $past(o_wk_count) - 1'b1)
        else $error("wake counter did not step down");
    AST_WK_ONESHOT: assert property (wk_fire && !i_wk_autoreload
                                     |=> s.wk_stop && o_wk_irq && o_wk_wake ##1 $stable(o_wk_count))
        else $error("single-shot wake timer did not stop with flags");
    AST_WK_RELOAD: assert property (wk_fire && i_wk_autoreload
                                    |=> !s.wk_stop && o_wk_count == $past(i_wk_load) && o_wk_wake)
        else $error("auto-reload wake timer did not reload");
    AST_TICK: assert property (o_tick |-> $past(s.tick_cnt) == '0 && $past(i_tick_en))
        else $error("tick without expiry");
    // The other watchdog may escalate on its own in the same cycle
    AST_WD_SERVICE: assert property (i_wd_en[0] && s.wd_run[0] && i_wd_service[0]
                                     && !wd_fire[1]
                                     |=> s.wd_cnt[0] == $past(wd_timeout[0])
                                         && !$rose(o_wd_irq[0]) && !$rose(o_sys_rst))
        else $error("service did not restart the watchdog");
    AST_WD_RESET: assert property (wd_second_expiry |=> rst_pulse)
        else $error("second expiry did not give a reset pulse");
    AST_WD_CORE: assert property (##1 o_wd_core_irq == $past(|next_s.wd_irq))
        else $error("core watchdog output off");

    for (genvar g = 0; g < 2; g++) begin : g_dt_chk
        AST_DT_PERIODIC: assert property (dt_fire[g] && dt_mode[g] == MODE_PERIODIC
                                          |=> s.dt_cnt[g] == $past(dt_load[g]) && o_dt_irq[g])
            else $error("periodic counter did not reload");
        AST_DT_FREE: assert property (dt_fire[g] && dt_mode[g] == MODE_FREE
                                      |=> s.dt_cnt[g] == '1 && o_dt_irq[g])
            else $error("free-running counter did not wrap");
        AST_DT_ONESHOT: assert property (dt_fire[g] && dt_mode[g] == MODE_ONESHOT
                                         |=> s.dt_stop[g] && o_dt_irq[g])
            else $error("one-shot counter did not stop");
    end
endmodule

//--- timer_pkg.sv
// Shared constants and types for the timer and watchdog group
package timer_pkg;
    localparam int          CNT_WIDTH       = 32;
    localparam int          SLEEP_DIV_RATIO = 64;
    localparam int          CLK_PERIOD_PS   = 5000;
    localparam int          WD_RST_TIME_NS  = 80;
    localparam int          WD_RST_CYCLES   = (WD_RST_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                              / CLK_PERIOD_PS;
    localparam int          RST_CNT_W       = 5;
    localparam logic        FLAG_RST        = 1'b0;
    localparam logic [31:0] COUNT_RST       = 32'h0000_0000;

    typedef enum logic [1:0] {
        MODE_FREE,
        MODE_PERIODIC,
        MODE_ONESHOT
    } dt_mode_t;
endpackage

//--- rc_osc_model.sv
// Free-running 2 MHz RC oscillator model feeding the sleep divider
`timescale 1ns/1ps
module rc_osc_model #(
    parameter real HALF_PERIOD = 250.0
) (
    // Oscillator output
    output logic o_clk
);
    // Odd start offset keeps its edges clear of the system clock edges
    initial begin
        o_clk = 1'b0;
        #1.3;
        forever #(HALF_PERIOD) o_clk = ~o_clk;
    end
endmodule

//--- test_timer_group.sv
// Self-checking bench for the timer and watchdog group
`timescale 1ns/1ps
module test_timer_group;
    import timer_pkg::*;
    // Roughly ten sleep ticks of wake traffic plus the fast tests
    localparam int LIMIT = 90000;
    logic        i_clk = 1'b0;
    logic        i_arst_n = 1'b0;
    logic        i_rc2m_clk;
    logic        i_tick_en, i_wk_en, i_wk_autoreload, i_wk_load_wr, i_wk_irq_clr, i_wk_wake_clr;
    logic [1:0]  i_dt_en, i_dt_load_wr, i_dt_irq_clr, i_wd_en, i_wd_service, i_wd_irq_clr;
    logic [31:0] i_tick_interval, i_dt0_load, i_dt1_load, i_wk_load, i_wd0_timeout, i_wd1_timeout;
    dt_mode_t    i_dt0_mode, i_dt1_mode;
    logic        o_sleep_clk, o_sleep_tick, o_tick, o_wk_irq, o_wk_wake, o_wd_core_irq, o_sys_rst;
    logic [1:0]  o_dt_irq, o_wd_irq;
    logic [31:0] o_dt0_count, o_dt1_count, o_wk_count;
    int          errors = 0;
    int          total_checks = 0;
    int          cycles = 0;

    rc_osc_model u_rc (.o_clk(i_rc2m_clk));
    timer_group #(.CNT_W(CNT_WIDTH), .SLEEP_DIV(SLEEP_DIV_RATIO)) u_dut (
        .i_clk, .i_arst_n, .i_rc2m_clk, .o_sleep_clk, .o_sleep_tick,
        .i_tick_en, .i_tick_interval, .o_tick,
        .i_dt_en, .i_dt_load_wr, .i_dt0_mode, .i_dt1_mode, .i_dt0_load, .i_dt1_load,
        .i_dt_irq_clr, .o_dt_irq, .o_dt0_count, .o_dt1_count,
        .i_wk_en, .i_wk_autoreload, .i_wk_load_wr, .i_wk_load, .i_wk_irq_clr,
        .i_wk_wake_clr, .o_wk_irq, .o_wk_wake, .o_wk_count,
        .i_wd_en, .i_wd_service, .i_wd0_timeout, .i_wd1_timeout, .i_wd_irq_clr,
        .o_wd_irq, .o_wd_core_irq, .o_sys_rst
    );

    initial begin
        forever #2.5 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask

    // Settled view just after an edge
    task automatic step;
        @(posedge i_clk);
        #1;
    endtask

    task automatic wait_sleep(output int t);
        int n;
        n = 0;
        do begin
            step;
            n++;
        end while (o_sleep_tick !== 1'b1 && n < 7000);
        t = cycles;
    endtask

    task automatic wait_wk_irq;
        int n;
        n = 0;
        while (o_wk_irq !== 1'b1 && n < 14000) begin
            step;
            n++;
        end
    endtask

    task automatic clear_wake;
        @(posedge i_clk);
        i_wk_irq_clr <= 1'b1;
        i_wk_wake_clr <= 1'b1;
        @(posedge i_clk);
        i_wk_irq_clr <= 1'b0;
        i_wk_wake_clr <= 1'b0;
        #1;
        check("wake flags cleared", 32'h0, {o_wk_irq, o_wk_wake});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_tick;
        int n;
        for (int v = 0; v <= 5; v += 5) begin
            @(posedge i_clk);
            i_tick_en <= 1'b0;
            @(posedge i_clk);
            i_tick_interval <= 32'(v);
            i_tick_en <= 1'b1;
            n = 0;
            do begin
                step;
                n++;
            end while (o_tick !== 1'b1 && n < 20);
            n = 0;
            do begin
                step;
                n++;
            end while (o_tick !== 1'b1 && n < 20);
            check("tick period", 32'(v + 1), 32'(n));
        end
        @(posedge i_clk);
        i_tick_en <= 1'b0;
        $display("test_tick done");
    endtask

    task automatic test_dual;
        logic [31:0] exp;
        for (int i = 0; i < 2; i++) begin
            for (int k = 0; k < 3; k++) begin
                exp = (k == 0) ? 32'hFFFF_FFFF : (k == 1) ? 32'h2 : 32'h0;
                @(posedge i_clk);
                i_dt0_mode <= dt_mode_t'(k);
                i_dt1_mode <= dt_mode_t'(k);
                i_dt0_load <= 32'h2;
                i_dt1_load <= 32'h2;
                i_dt_en <= 2'b01 << i;
                i_dt_load_wr <= 2'b01 << i;
                @(posedge i_clk);
                i_dt_load_wr <= 2'b00;
                repeat (2) step;
                check("dt irq before expiry", 32'h0, o_dt_irq);
                step;
                check("dt irq on expiry", 32'(2'b01 << i), o_dt_irq);
                check("dt count after expiry", exp, i ? o_dt1_count : o_dt0_count);
                // One-shot keeps running enable to show that it has stopped
                @(posedge i_clk);
                i_dt_en <= (k == 2) ? i_dt_en : 2'b00;
                i_dt_irq_clr <= 2'b11;
                @(posedge i_clk);
                i_dt_irq_clr <= 2'b00;
                repeat (3) step;
                check("dt irq after clear", 32'h0, o_dt_irq);
            end
        end
        $display("test_dual done");
    endtask

    task automatic test_watchdog;
        int n;
        for (int i = 0; i < 2; i++) begin
            @(posedge i_clk);
            i_wd0_timeout <= 32'h14;
            i_wd1_timeout <= 32'h14;
            i_wd_en <= 2'b01 << i;
            repeat (4) begin
                repeat (10) @(posedge i_clk);
                i_wd_service <= 2'b01 << i;
                @(posedge i_clk);
                i_wd_service <= 2'b00;
            end
            #1;
            check("wd irq while serviced", 32'h0, {o_wd_irq, o_wd_core_irq, o_sys_rst});
            n = 0;
            while (o_wd_irq[i] !== 1'b1 && n < 40) begin
                step;
                n++;
            end
            // Last service reloads the count; it expires timeout plus one cycles later
            check("wd expiry cycles", 32'h15, 32'(n));
            check("wd core irq", 32'h1, o_wd_core_irq);
            check("sys rst on first expiry", 32'h0, o_sys_rst);
            n = 0;
            while (o_sys_rst !== 1'b1 && n < 40) begin
                step;
                n++;
            end
            n = 0;
            while (o_sys_rst === 1'b1 && n < 40) begin
                step;
                n++;
            end
            check("sys rst width", 32'(WD_RST_CYCLES), 32'(n));
            @(posedge i_clk);
            i_wd_en <= 2'b00;
            i_wd_irq_clr <= 2'b11;
            @(posedge i_clk);
            i_wd_irq_clr <= 2'b00;
            #1;
            check("wd flags cleared", 32'h0, {o_wd_irq, o_wd_core_irq});
        end
        $display("test_watchdog done");
    endtask

    task automatic test_wake;
        int t1, t2;
        int n;
        logic [31:0] c1;
        @(posedge i_clk);
        i_wk_en <= 1'b1;
        i_wk_load <= 32'h2;
        i_wk_load_wr <= 1'b1;
        @(posedge i_clk);
        i_wk_load_wr <= 1'b0;
        wait_sleep(t1);
        step;
        c1 = o_wk_count;
        wait_sleep(t2);
        step;
        check("sleep tick spacing", 32'h1, 32'(t2 - t1 >= 6399 && t2 - t1 <= 6401));
        check("wake first step", 32'h1, c1);
        check("wake second step", 32'h0, o_wk_count);
        wait_wk_irq;
        check("wake irq and request", 32'h3, {o_wk_irq, o_wk_wake});
        clear_wake;
        wait_sleep(t1);
        // Sleep clock toggles every 32 source periods of 100 system clocks
        n = 0;
        c1 = {31'h0, o_sleep_clk};
        do begin
            step;
            n++;
        end while (o_sleep_clk === c1[0] && n < 4000);
        check("sleep clock half period", 32'hC80, 32'(n));
        wait_sleep(t2);
        step;
        check("single shot flags", 32'h0, {o_wk_irq, o_wk_wake});
        check("single shot count", 32'h0, o_wk_count);
        @(posedge i_clk);
        i_wk_autoreload <= 1'b1;
        i_wk_load <= 32'h1;
        i_wk_load_wr <= 1'b1;
        @(posedge i_clk);
        i_wk_load_wr <= 1'b0;
        wait_wk_irq;
        check("auto reload count", 32'h1, o_wk_count);
        clear_wake;
        wait_wk_irq;
        check("auto reload again", 32'h3, {o_wk_irq, o_wk_wake});
        @(posedge i_clk);
        i_wk_en <= 1'b0;
        $display("test_wake done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            give_verdict;
        end
    end

    initial begin
        {i_tick_en, i_wk_en, i_wk_autoreload, i_wk_load_wr, i_wk_irq_clr, i_wk_wake_clr} = '0;
        {i_dt_en, i_dt_load_wr, i_dt_irq_clr, i_wd_en, i_wd_service, i_wd_irq_clr} = '0;
        {i_tick_interval, i_dt0_load, i_dt1_load, i_wk_load, i_wd0_timeout, i_wd1_timeout} = '0;
        i_dt0_mode = MODE_FREE;
        i_dt1_mode = MODE_FREE;
        repeat (5) @(posedge i_clk);
        i_arst_n <= 1'b1;
        step;
        test_tick;
        test_dual;
        test_watchdog;
        test_wake;
        give_verdict;
    end
endmodule
